// ### rtl/mmsp_pkg.sv
// package: shared constants for the memory-mapped slave port
package mmsp_pkg;
  // ************************************************************
  // data and address shape
  // ************************************************************
  localparam int DATA_W_DEF  = 32;
  localparam int ADDR_W_DEF  = 4;
  localparam int DATA_W_MIN  = 1;
  localparam int DATA_W_MAX  = 1024;
  localparam int LANE_W      = 8;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic WORD_RST_BIT = 1'b0;
  localparam logic SEEN_RST     = 1'b0;
  // ************************************************************
  // strobe usage modes
  // ************************************************************
  typedef enum logic [2:0] {
    MMSP_STB_BOTH    = 3'h1,
    MMSP_STB_RD_ONLY = 3'h2,
    MMSP_STB_WR_ONLY = 3'h4
  } mmsp_stb_mode_t;
endpackage

// ### rtl/mmsp_store_if.sv
// interface: port logic to word store connection
`timescale 1ns/1ps
interface mmsp_store_if #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4
);
  localparam int LANES = (DATA_W + 7) / 8;
  logic [LANES-1:0]  we_lanes;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport port (output we_lanes, output waddr, output wdata, output raddr, input rdata);
  modport store (input we_lanes, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### rtl/mmsp_word_store.sv
// module: flip-flop word store with per-lane write and asynchronous read
`timescale 1ns/1ps
module mmsp_word_store #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  mmsp_store_if.store st
);
  localparam int LANES = (DATA_W + 7) / 8;
  localparam int WORDS = 1 << ADDR_W;

  logic [DATA_W-1:0] mem_q [WORDS];
  logic [DATA_W-1:0] mem_d [WORDS];

  // ************************************************************
  // next value per word and lane
  // ************************************************************
  always_comb begin
    for (int w = 0; w < WORDS; w++) begin
      mem_d[w] = mem_q[w];
      for (int l = 0; l < LANES; l++) begin
        for (int b = l * 8; b < (l + 1) * 8 && b < DATA_W; b++) begin
          // only the marked lanes of the addressed word change
          if (st.we_lanes[l] && st.waddr == ADDR_W'(w)) begin // R13
            mem_d[w][b] = st.wdata[b];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int w = 0; w < WORDS; w++) begin
      if (sys_rst) begin
        mem_q[w] <= {DATA_W{mmsp_pkg::WORD_RST_BIT}};
      end else begin
        mem_q[w] <= mem_d[w];
      end
    end
  end

  // no register on the read side, so the word is ready within the cycle
  assign st.rdata = mem_q[st.raddr]; // R21

  // ************************************************************
  // checks
  // ************************************************************
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane_chk
      localparam int HI = ((gl + 1) * 8 < DATA_W) ? (gl + 1) * 8 - 1 : DATA_W - 1;
      a_lane_untouched: assert property (@(posedge clk) disable iff (sys_rst) // R13
        !st.we_lanes[gl] |=> mem_q[$past(st.waddr)][HI:gl*8] == $past(mem_q[st.waddr][HI:gl*8]))
        else $error("unmarked lane changed");
    end
  endgenerate
endmodule

// ### rtl/mmsp_slave_port.sv
// module: zero-wait memory-mapped slave port with byte-lane writes
`timescale 1ns/1ps
// Operation
// R1: fabric ignores slave outputs while idle
// R2: address selects one whole data word
// R3: data ports one to 1024 bits
// R4: dynamic sizing widths are powers 8..1024
// R5: read and write data share width
// R6: select asserted takes transfer, else ignored
// R7: fabric raises select only with strobe
// R8: lone strobe low means opposite direction
// R9: select qualifies both strobes
// R10: without select, fabric raises one strobe
// R11: back-to-back reads with strobes held
// R12: unselected slave ignores inputs but reset
// R13: write only lanes marked in mask
// R14: reads return all lanes valid
// R15: fabric keeps multi-lane masks aligned
// R16: fabric uses only legal 32-bit masks
// R17: write lane mask is write AND mask
// R18: fabric pulses first-cycle flag each transfer
// R19: basic read finishes in one cycle
// R20: fabric samples word on next edge
// R21: read word driven combinationally when selected
// R22: no registered read path here
// R23: act only on clock-edge stable levels
// R24: strobes may be active low
module mmsp_slave_port #(
  parameter int                      DATA_W      = mmsp_pkg::DATA_W_DEF,
  parameter int                      ADDR_W      = mmsp_pkg::ADDR_W_DEF,
  parameter bit                      DYN_SIZING  = 1'b0,
  parameter bit                      HAS_SELECT  = 1'b1,
  parameter mmsp_pkg::mmsp_stb_mode_t STB_MODE   = mmsp_pkg::MMSP_STB_BOTH,
  parameter bit                      LOW_ACTIVE  = 1'b0
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [ADDR_W-1:0]           address,
  input  wire logic                        chipselect,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [(DATA_W+7)/8-1:0]     byteenable,
  input  wire logic [DATA_W-1:0]           writedata,
  input  wire logic                        begintransfer,
  output logic      [DATA_W-1:0]           readdata,
  output logic                             xfer_seen_q,
  output logic                             wrote_q
);
  localparam int LANES = (DATA_W + 7) / 8;

  // ************************************************************
  // elaboration checks on the data width
  // ************************************************************
  generate
    if (DATA_W < mmsp_pkg::DATA_W_MIN || DATA_W > mmsp_pkg::DATA_W_MAX) begin : g_bad_w // R3
      $error("data width out of range");
    end
    if (DYN_SIZING && (DATA_W < 8 || (DATA_W & (DATA_W - 1)) != 0)) begin : g_bad_dyn // R4
      $error("dynamic sizing needs a power-of-two width of 8 or more");
    end
  endgenerate

  // ************************************************************
  // strobe decode
  // ************************************************************
  // one function serves both directions so the two can never disagree
  function automatic logic [1:0] dir_decode(input logic cs, input logic rd, input logic wr);
    logic sel;
    logic [1:0] rw;
    sel = HAS_SELECT ? cs : 1'b1;
    rw  = 2'b00;
    case (STB_MODE)
      mmsp_pkg::MMSP_STB_RD_ONLY: begin
        if (HAS_SELECT) begin
          rw = sel ? {rd, ~rd} : 2'b00; // R8
        end else begin
          rw = {rd, 1'b0};
        end
      end
      mmsp_pkg::MMSP_STB_WR_ONLY: begin
        if (HAS_SELECT) begin
          rw = sel ? {~wr, wr} : 2'b00; // R8
        end else begin
          rw = {1'b0, wr};
        end
      end
      default: begin
        // select only qualifies; strobes without it are dropped
        rw = sel ? {rd, wr} : 2'b00; // R9
      end
    endcase
    return rw;
  endfunction

  logic cs_lvl;
  logic rd_lvl;
  logic wr_lvl;
  logic bt_lvl;
  logic rd_eff;
  logic wr_eff;

  // a low-active build inverts the strobes here and nowhere else
  assign cs_lvl = chipselect ^ LOW_ACTIVE; // R24
  assign rd_lvl = read ^ LOW_ACTIVE;
  assign wr_lvl = write ^ LOW_ACTIVE;
  assign bt_lvl = begintransfer ^ LOW_ACTIVE;

  always_comb begin
    logic [1:0] rw;
    rw     = dir_decode(cs_lvl, rd_lvl, wr_lvl); // R6 R12
    rd_eff = rw[1];
    wr_eff = rw[0];
  end

  // ************************************************************
  // word store
  // ************************************************************
  mmsp_store_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) st ();

  // writes land at the clock edge, addressed as a word index
  assign st.we_lanes = {LANES{wr_eff}} & byteenable; // R17 R13
  assign st.waddr    = address; // R2
  assign st.wdata    = writedata; // R5
  assign st.raddr    = address; // R2

  mmsp_word_store #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_store (
    .clk     (clk),
    .sys_rst (sys_rst),
    .st      (st)
  );

  // ************************************************************
  // read return
  // ************************************************************
  // combinational on purpose: a single-cycle read cannot afford a register
  // here, so this output alone is not taken from a flip-flop
  always_comb begin
    if (rd_eff) begin
      readdata = st.rdata; // R21 R19 R14 R22
    end else begin
      // idle value is don't-care to the fabric; zero keeps it quiet
      readdata = '0; // R1
    end
  end

  // ************************************************************
  // transfer status flags
  // ************************************************************
  logic xfer_seen_d;
  logic wrote_d;

  always_comb begin
    // begin flag sampled only at the edge, never used as an edge itself
    xfer_seen_d = bt_lvl && (rd_eff || wr_eff); // R23
    wrote_d     = wr_eff && (|byteenable);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xfer_seen_q <= mmsp_pkg::SEEN_RST;
      wrote_q     <= mmsp_pkg::SEEN_RST;
    end else begin
      xfer_seen_q <= xfer_seen_d;
      wrote_q     <= wrote_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_full_write;
    wr_eff && (&byteenable);
  endsequence

  sequence s_read_same;
    rd_eff && address == $past(address);
  endsequence

  a_read_after_write: assert property (@(posedge clk) disable iff (sys_rst) // R19
    s_full_write ##1 s_read_same |-> readdata == $past(writedata))
    else $error("read did not return the word just written");

  a_read_same_cycle: assert property (@(posedge clk) disable iff (sys_rst) // R21
    rd_eff |-> readdata == st.rdata)
    else $error("read word not driven in the selected cycle");

  a_back_to_back: assert property (@(posedge clk) disable iff (sys_rst) // R11
    (cs_lvl && rd_lvl) ##1 (cs_lvl && rd_lvl) |-> readdata == st.rdata && st.raddr == address)
    else $error("second back-to-back read not served");

  a_unselected_idle: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (HAS_SELECT && !cs_lvl) |-> st.we_lanes == '0 && !rd_eff)
    else $error("transfer taken without select");

  a_select_qualifies: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_BOTH && cs_lvl) |-> rd_eff == rd_lvl && wr_eff == wr_lvl)
    else $error("strobes not passed through under select");

  a_lone_read_low: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_RD_ONLY && cs_lvl && !rd_lvl) |-> wr_eff)
    else $error("lone read strobe low did not mean write");

  a_write_mask: assert property (@(posedge clk) disable iff (sys_rst) // R17
    st.we_lanes == ({LANES{wr_eff}} & byteenable))
    else $error("write lane mask not write and mask");

  a_begin_flag: assert property (@(posedge clk) disable iff (sys_rst) // R23
    (bt_lvl && rd_eff) |=> xfer_seen_q ##1 !xfer_seen_q || $past(xfer_seen_d))
    else $error("first-cycle flag not registered");

  a_word_index: assert property (@(posedge clk) disable iff (sys_rst) // R2
    wr_eff |-> st.waddr == address)
    else $error("write address not the word index");

  // ************************************************************
  // decode, status flag and store checks
  // ************************************************************
  // a write followed at once by a read of the same word, and a read held
  sequence s_same_addr;
    address == $past(address);
  endsequence

  // a reset cycle just before would make the past store value meaningless
  sequence s_held_read;
    rd_eff && $past(rd_eff) && !$past(sys_rst);
  endsequence

  sequence s_quiet_store;
    $past(st.we_lanes) == '0;
  endsequence

  a_write_lands: assert property (@(posedge clk) disable iff (sys_rst) // R13
    s_full_write ##1 s_same_addr |-> st.rdata == $past(writedata))
    else $error("full write did not reach the store");

  a_read_holds: assert property (@(posedge clk) disable iff (sys_rst) // R11
    s_held_read ##0 s_same_addr ##0 s_quiet_store |-> $stable(readdata))
    else $error("held read word changed without a write");

  a_idle_read_zero: assert property (@(posedge clk) disable iff (sys_rst) // R1
    !rd_eff |-> readdata == '0)
    else $error("idle read word not zero");

  a_read_addr: assert property (@(posedge clk) disable iff (sys_rst) // R2
    rd_eff |-> st.raddr == address)
    else $error("read address not the word index");

  a_no_lanes_idle: assert property (@(posedge clk) disable iff (sys_rst) // R13
    !wr_eff |-> st.we_lanes == '0)
    else $error("lane written without a write");

  a_wrote_set: assert property (@(posedge clk) disable iff (sys_rst) // R17
    (wr_eff && (|byteenable)) |=> wrote_q)
    else $error("write flag not raised");

  a_wrote_clear: assert property (@(posedge clk) disable iff (sys_rst) // R17
    !wr_eff |=> !wrote_q)
    else $error("write flag raised without a write");

  a_empty_mask: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (wr_eff && byteenable == '0) |=> !wrote_q)
    else $error("write flag raised with no lane");

  a_seen_on_write: assert property (@(posedge clk) disable iff (sys_rst) // R23
    (bt_lvl && wr_eff) |=> xfer_seen_q)
    else $error("first-cycle flag missed on a write");

  a_seen_clear: assert property (@(posedge clk) disable iff (sys_rst) // R23
    !bt_lvl |=> !xfer_seen_q)
    else $error("first-cycle flag without begin");

  a_unsel_no_flags: assert property (@(posedge clk) disable iff (sys_rst) // R12
    (HAS_SELECT && !cs_lvl) |=> !xfer_seen_q && !wrote_q)
    else $error("status flag set while unselected");

  a_dir_exclusive: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (STB_MODE != mmsp_pkg::MMSP_STB_BOTH) |-> !(rd_eff && wr_eff))
    else $error("single strobe gave both directions");

  a_lone_read_high: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_RD_ONLY && cs_lvl && rd_lvl) |-> rd_eff && !wr_eff)
    else $error("lone read strobe high did not mean read");

  a_lone_write_low: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_WR_ONLY && cs_lvl && !wr_lvl) |-> rd_eff)
    else $error("lone write strobe low did not mean read");

  a_lone_write_high: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_WR_ONLY && cs_lvl && wr_lvl) |-> wr_eff && !rd_eff)
    else $error("lone write strobe high did not mean write");

  a_nosel_direct: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (!HAS_SELECT && STB_MODE == mmsp_pkg::MMSP_STB_BOTH) |-> rd_eff == rd_lvl && wr_eff == wr_lvl)
    else $error("strobes not used directly without select");
endmodule

// ### bench/mmsp_fab_model.sv
// partner: fabric model driving the slave port bus side
`timescale 1ns/1ps
module mmsp_fab_model #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4
) (
  input  wire logic                clk,
  output logic [ADDR_W-1:0]        address,
  output logic                     chipselect,
  output logic                     read,
  output logic                     write,
  output logic [(DATA_W+7)/8-1:0]  byteenable,
  output logic [DATA_W-1:0]        writedata,
  output logic                     begintransfer,
  input  wire logic [DATA_W-1:0]   readdata
);
  initial begin
    address = '0;
    writedata = '0;
    byteenable = '0;
    {chipselect, read, write, begintransfer} = 4'h0;
  end
  // released lines flip so a stale value never passes by luck
  task automatic idle();
    @(negedge clk);
    {chipselect, read, write, begintransfer} = 4'h0;
    address = ~address;
    writedata = ~writedata;
  endtask
  // strobes stay up at the end so transfers can chain back to back
  task automatic xfer(input logic cs, input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [(DATA_W+7)/8-1:0] be, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    @(negedge clk);
    address = a;
    byteenable = be;
    writedata = d;
    chipselect = cs;
    read = ~wr;
    write = wr;
    begintransfer = cs;
    @(posedge clk);
    q = readdata;
  endtask
endmodule

// ### bench/tb.sv
// testbench: self-checking bench for the slave port
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  address;
  logic        chipselect;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic        begintransfer;
  logic [31:0] readdata;
  logic        xfer_seen_q;
  logic        wrote_q;
  logic [31:0] readdata_ro;
  logic        xfer_seen_ro;
  logic        wrote_ro;
  logic [31:0] q;
  int          error_cnt;
  int          checks_done;
  int          cyc;

  mmsp_slave_port #(.DATA_W(32), .ADDR_W(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .address(address),
    .chipselect(chipselect), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .begintransfer(begintransfer), .readdata(readdata), .xfer_seen_q(xfer_seen_q), .wrote_q(wrote_q));
  // read-strobe-only build on the same bus: read low under select is a write
  mmsp_slave_port #(.DATA_W(32), .ADDR_W(4), .STB_MODE(mmsp_pkg::MMSP_STB_RD_ONLY)) u_dut_ro (.clk(clk),
    .sys_rst(sys_rst), .address(address), .chipselect(chipselect), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .begintransfer(begintransfer), .readdata(readdata_ro),
    .xfer_seen_q(xfer_seen_ro), .wrote_q(wrote_ro));
  mmsp_fab_model #(.DATA_W(32), .ADDR_W(4)) u_fab (.clk(clk), .address(address), .chipselect(chipselect),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .begintransfer(begintransfer), .readdata(readdata));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] pat(input int a);
    return 32'h5a00_00c3 ^ (32'h0101_0101 * 32'(a));
  endfunction
  task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    u_fab.xfer(1'b1, 1'b1, a, be, d, q);
    u_fab.idle();
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] be);
    u_fab.xfer(1'b1, 1'b0, a, be, 32'h0, q);
    u_fab.idle();
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_state();
    `CHK({xfer_seen_q, wrote_q}, 2'h0)
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], 4'hf);
      `CHK(q, 32'h0)
    end
  endtask
  task automatic t_write_read();
    for (int a = 0; a < 16; a++) begin
      wr(a[3:0], 4'hf, pat(a));
      `CHK({xfer_seen_q, wrote_q}, 2'h3)
      `CHK({xfer_seen_ro, wrote_ro}, 2'h3)
    end
    for (int a = 15; a >= 0; a--) begin
      u_fab.xfer(1'b1, 1'b0, a[3:0], 4'hf, 32'h0, q);
      `CHK(q, pat(a))
      `CHK(readdata_ro, pat(a))
    end
    u_fab.idle();
    `CHK({xfer_seen_q, wrote_q}, 2'h2)
  endtask
  task automatic t_lanes();
    logic [3:0]  m [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
    logic [31:0] e;
    for (int i = 0; i < 7; i++) begin
      wr(4'h3, 4'hf, 32'hffff_ffff);
      wr(4'h3, m[i], 32'h0);
      e = 32'hffff_ffff;
      for (int b = 0; b < 4; b++) if (m[i][b]) e[8*b+:8] = 8'h00;
      rd(4'h3, m[i]);
      `CHK(q, e)
    end
  endtask
  task automatic t_chain();
    u_fab.xfer(1'b1, 1'b1, 4'h9, 4'hf, 32'hc0de_0009, q);
    u_fab.xfer(1'b1, 1'b0, 4'h9, 4'h3, 32'h0, q);
    `CHK(q, 32'hc0de_0009)
    u_fab.xfer(1'b1, 1'b0, 4'h9, 4'hc, 32'h0, q);
    `CHK(q, 32'hc0de_0009)
    u_fab.idle();
  endtask
  task automatic t_desel();
    wr(4'h5, 4'hf, 32'h1357_9bdf);
    u_fab.xfer(1'b0, 1'b1, 4'h5, 4'hf, 32'h2468_ace0, q);
    u_fab.idle();
    `CHK({xfer_seen_q, wrote_q}, 2'h0)
    rd(4'h5, 4'hf);
    `CHK(q, 32'h1357_9bdf)
  endtask
  task automatic t_midreset();
    wr(4'h7, 4'hf, 32'h0bad_0007);
    @(negedge clk) sys_rst = 1'b1;
    @(negedge clk) sys_rst = 1'b0;
    `CHK({xfer_seen_q, wrote_q}, 2'h0)
    rd(4'h7, 4'hf);
    `CHK(q, 32'h0)
  endtask

  // ************************************************************
  // run control
  // ************************************************************
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is well under 200 cycles; the ceiling of 2000 leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_reset_state();
    t_write_read();
    t_lanes();
    t_chain();
    t_desel();
    t_midreset();
    tally_and_finish();
  end
endmodule
